// [evpu_defines.vh]
// Constants for the exception vector and priority unit.
// Assumes inclusion by bare name from design files in the same folder.
`ifndef EVPU_DEFINES_VH
`define EVPU_DEFINES_VH

// Vector numbers
`define EVPU_VEC_RESET      8'h00
`define EVPU_VEC_BUS_ERR    8'h02
`define EVPU_VEC_ADDR_ERR   8'h03
`define EVPU_VEC_ILLEGAL    8'h04
`define EVPU_VEC_ZERO_DIV   8'h05
`define EVPU_VEC_BOUNDS     8'h06
`define EVPU_VEC_OVF_TRAP   8'h07
`define EVPU_VEC_PRIV       8'h08
`define EVPU_VEC_TRACE      8'h09
`define EVPU_VEC_LINE_A     8'h0a
`define EVPU_VEC_LINE_F     8'h0b
`define EVPU_VEC_UNINIT     8'h0f
`define EVPU_VEC_SPURIOUS   8'h18
`define EVPU_VEC_AUTO_BASE  8'h18
`define EVPU_VEC_SWI_BASE   8'h20
`define EVPU_VEC_USER_FIRST 8'h40

// Vector address formation
`define EVPU_VEC_SHIFT      2
`define EVPU_ADDR_W         32

// Reset entry is four words, other entries two
`define EVPU_WORDS_RESET    3'h4
`define EVPU_WORDS_NORMAL   3'h2

// Address space codes
`define EVPU_FC_SUP_DATA    3'h5
`define EVPU_FC_SUP_PROG    3'h6

// Group 0 start latency, in clock cycles
`define EVPU_ABORT_MAX_CYC  2

`endif

// [evpu_src_latch.v]
// Sticky pending flag for one exception source.
// Assumes set and clear are synchronous to clk_i.
`timescale 1ns/1ps
module evpu_src_latch (
  input  wire clk_i,
  input  wire rst_b_i,
  input  wire set_i,
  input  wire clr_i,
  input  wire flush_i,
  output wire pend_o
);
  reg pend_q;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_q <= 1'b0;
    end else if (set_i) begin
      pend_q <= 1'b1;
    end else if (clr_i || flush_i) begin
      pend_q <= 1'b0;
    end
  end
  assign pend_o = pend_q;
endmodule // evpu_src_latch

// [evpu_vec_addr.v]
// Forms a vector address, space and entry length from a vector number.
// Assumes a combinational use by the sequencer side.
`timescale 1ns/1ps
`include "evpu_defines.vh"
module evpu_vec_addr (
  input  wire [7:0]  vec_i,
  output wire [31:0] addr_o,
  output wire [2:0]  space_o,
  output wire [2:0]  words_o
);
  assign addr_o  = {22'h000000, vec_i, 2'h0};
  assign space_o = (vec_i == `EVPU_VEC_RESET) ? `EVPU_FC_SUP_PROG : `EVPU_FC_SUP_DATA;
  assign words_o = (vec_i == `EVPU_VEC_RESET) ? `EVPU_WORDS_RESET : `EVPU_WORDS_NORMAL;
endmodule // evpu_vec_addr

// [evpu_exception_unit.v]
// Exception classification, vectoring and priority for the sequencer.
// Assumes all inputs synchronous to clk_i; one request taken per take pulse.
// Summary of operation
// - External sources are only interrupts, bus error and reset.
// - Internal exceptions: trap, overflow, bounds, divide, illegal, odd fetch, privilege, trace.
// - Tracing raises a high priority exception after each completed instruction.
// - Reset entry vector 0 spans four words: stack pointer then counter.
// - Reset vectors in supervisor program space, others in supervisor data space.
// - Autovector uses 24 plus level, giving 25 to 31.
// - Bus error during acknowledge gives spurious vector 24.
// - Software interrupt n selects vector 32 plus n.
// - Reset, address and bus error abort; processing begins within two cycles.
// - Trace and interrupt wait for instruction end, then preempt next.
// - Illegal or privileged instruction trapped before it executes.
// - Trap, overflow, bounds and zero divide come from normal execution.
// - Group 0 over 1 over 2; reset, address error, bus error.
// - Group 1: trace, interrupt, then illegal and privilege.
// - Bus error during software interrupt replaces that exception.
// - Interrupt pending with trace: trace first, then interrupt too.
// - Trap, trace, interrupt processed in that order.
// - Reset clears every other latched pending exception.
// - Vector address is number shifted left two, upper bits zero.
// - Vectors 64 to 255 available as user interrupt vectors.
`timescale 1ns/1ps
`include "evpu_defines.vh"
module evpu_exception_unit (
  input  wire        clk_i,
  input  wire        rst_b_i,
  input  wire        reset_req_i,
  input  wire        bus_err_i,
  input  wire        addr_err_i,
  input  wire [2:0]  irq_level_i,
  input  wire [2:0]  irq_mask_i,
  input  wire        trace_en_i,
  input  wire        instr_done_i,
  input  wire        next_illegal_i,
  input  wire        next_priv_i,
  input  wire        next_line_a_i,
  input  wire        next_line_f_i,
  input  wire        swi_i,
  input  wire [3:0]  swi_num_i,
  input  wire        overflow_trap_instr_i,
  input  wire        bounds_check_instr_i,
  input  wire        zero_div_i,
  input  wire        iack_done_i,
  input  wire        iack_auto_i,
  input  wire        iack_berr_i,
  input  wire        iack_uninit_i,
  input  wire [15:0] iack_data_i,
  input  wire        take_i,
  output wire        abort_o,
  output wire        preempt_o,
  output wire        exc_req_o,
  output wire        iack_req_o,
  output wire [2:0]  iack_level_o,
  output reg  [7:0]  vec_num_o,
  output reg  [31:0] vec_addr_o,
  output reg  [2:0]  vec_space_o,
  output reg  [2:0]  vec_words_o,
  output reg  [1:0]  vec_group_o,
  output reg         vec_valid_o
);

  ////////////////////////////////////////////////////////////////////////////
  // States
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_IACK = 4'b0010;
  localparam [3:0] ST_VEC  = 4'b0100;
  localparam [3:0] ST_HOLD = 4'b1000;

  reg  [3:0] state_q;
  reg  [3:0] state_d;

  ////////////////////////////////////////////////////////////////////////////
  // Pending sources
  wire reset_p;
  wire addr_p;
  wire berr_p;
  wire trace_p;
  wire swi_p;
  wire ovf_p;
  wire bnd_p;
  wire zdiv_p;
  wire irq_hit;
  reg  [3:0] swi_num_q;
  reg  [7:0] sel_vec;
  reg  [1:0] sel_grp;
  reg  [3:0] clr_sel;
  wire flush_all;
  wire flush_low;
  wire take_now;
  wire [31:0] fa_addr;
  wire [2:0]  fa_space;
  wire [2:0]  fa_words;

  assign flush_all = reset_req_i;
  assign flush_low = flush_all | bus_err_i | addr_err_i;
  assign take_now  = take_i & (state_q == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Clear strobes for the source being taken
  wire clr_reset;
  wire clr_addr;
  wire clr_berr;
  wire clr_trace;
  wire clr_swi;
  wire clr_ovf;
  wire clr_bnd;
  wire clr_zdiv;
  assign clr_reset = take_now & (clr_sel == 4'h1);
  assign clr_addr  = take_now & (clr_sel == 4'h2);
  assign clr_berr  = take_now & (clr_sel == 4'h3);
  assign clr_trace = take_now & (clr_sel == 4'h4);
  assign clr_swi   = take_now & (clr_sel == 4'h5);
  assign clr_ovf   = take_now & (clr_sel == 4'h6);
  assign clr_bnd   = take_now & (clr_sel == 4'h7);
  assign clr_zdiv  = take_now & (clr_sel == 4'h8);

  evpu_src_latch u_reset (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .set_i   (reset_req_i),
    .clr_i   (clr_reset),
    .flush_i (1'b0),
    .pend_o  (reset_p)
  );
  evpu_src_latch u_addr (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .set_i   (addr_err_i & ~reset_req_i),
    .clr_i   (clr_addr),
    .flush_i (flush_all),
    .pend_o  (addr_p)
  );
  evpu_src_latch u_berr (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .set_i   (bus_err_i & ~reset_req_i & (state_q != ST_IACK)),
    .clr_i   (clr_berr),
    .flush_i (flush_all),
    .pend_o  (berr_p)
  );
  evpu_src_latch u_trace (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .set_i   (trace_en_i & instr_done_i & ~flush_low),
    .clr_i   (clr_trace),
    .flush_i (flush_low),
    .pend_o  (trace_p)
  );
  evpu_src_latch u_swi (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .set_i   (swi_i & ~flush_low),
    .clr_i   (clr_swi),
    .flush_i (flush_low),
    .pend_o  (swi_p)
  );
  evpu_src_latch u_ovf (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .set_i   (overflow_trap_instr_i & ~flush_low),
    .clr_i   (clr_ovf),
    .flush_i (flush_low),
    .pend_o  (ovf_p)
  );
  evpu_src_latch u_bnd (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .set_i   (bounds_check_instr_i & ~flush_low),
    .clr_i   (clr_bnd),
    .flush_i (flush_low),
    .pend_o  (bnd_p)
  );
  evpu_src_latch u_zdiv (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .set_i   (zero_div_i & ~flush_low),
    .clr_i   (clr_zdiv),
    .flush_i (flush_low),
    .pend_o  (zdiv_p)
  );

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      swi_num_q <= 4'h0;
    end else if (swi_i) begin
      swi_num_q <= swi_num_i;
    end
  end

  // Interrupt level above the mask or at level 7, sampled between instructions
  assign irq_hit = (irq_level_i != 3'h0) &&
                   ((irq_level_i == 3'h7) || (irq_level_i > irq_mask_i));

  ////////////////////////////////////////////////////////////////////////////
  // Priority selection: lowest priority taken first, except group 0
  always @* begin
    sel_vec = 8'h00;
    sel_grp = 2'h3;
    clr_sel = 4'h0;
    if (reset_p) begin
      sel_vec = `EVPU_VEC_RESET;
      sel_grp = 2'h0;
      clr_sel = 4'h1;
    end else if (addr_p) begin
      sel_vec = `EVPU_VEC_ADDR_ERR;
      sel_grp = 2'h0;
      clr_sel = 4'h2;
    end else if (berr_p) begin
      sel_vec = `EVPU_VEC_BUS_ERR;
      sel_grp = 2'h0;
      clr_sel = 4'h3;
    end else if (swi_p) begin
      sel_vec = `EVPU_VEC_SWI_BASE + {4'h0, swi_num_q};
      sel_grp = 2'h2;
      clr_sel = 4'h5;
    end else if (ovf_p) begin
      sel_vec = `EVPU_VEC_OVF_TRAP;
      sel_grp = 2'h2;
      clr_sel = 4'h6;
    end else if (bnd_p) begin
      sel_vec = `EVPU_VEC_BOUNDS;
      sel_grp = 2'h2;
      clr_sel = 4'h7;
    end else if (zdiv_p) begin
      sel_vec = `EVPU_VEC_ZERO_DIV;
      sel_grp = 2'h2;
      clr_sel = 4'h8;
    end else if (trace_p) begin
      sel_vec = `EVPU_VEC_TRACE;
      sel_grp = 2'h1;
      clr_sel = 4'h4;
    end else if (irq_hit) begin
      sel_vec = 8'h00;
      sel_grp = 2'h1;
      clr_sel = 4'h9;
    end else if (next_illegal_i) begin
      sel_vec = `EVPU_VEC_ILLEGAL;
      sel_grp = 2'h1;
      clr_sel = 4'ha;
    end else if (next_priv_i) begin
      sel_vec = `EVPU_VEC_PRIV;
      sel_grp = 2'h1;
      clr_sel = 4'hb;
    end else if (next_line_a_i) begin
      sel_vec = `EVPU_VEC_LINE_A;
      sel_grp = 2'h1;
      clr_sel = 4'hc;
    end else if (next_line_f_i) begin
      sel_vec = `EVPU_VEC_LINE_F;
      sel_grp = 2'h1;
      clr_sel = 4'hd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer-facing requests
  assign abort_o   = reset_p | addr_p | berr_p;
  assign preempt_o = (clr_sel != 4'h0) & ~abort_o;
  assign exc_req_o = (state_q == ST_IDLE) & (clr_sel != 4'h0);
  assign iack_req_o   = (state_q == ST_IACK);
  reg [2:0] iack_level_q;
  assign iack_level_o = iack_level_q;

  ////////////////////////////////////////////////////////////////////////////
  // State machine
  reg [7:0] next_vec;
  always @* begin
    state_d  = state_q;
    next_vec = vec_num_o;
    case (state_q)
      ST_IDLE: begin
        if (take_now && clr_sel == 4'h9) begin
          state_d = ST_IACK;
        end else if (take_now && clr_sel != 4'h0) begin
          state_d  = ST_VEC;
          next_vec = sel_vec;
        end
      end
      ST_IACK: begin
        if (reset_req_i) begin
          state_d = ST_IDLE;
        end else if (iack_berr_i || bus_err_i) begin
          state_d  = ST_VEC;
          next_vec = `EVPU_VEC_SPURIOUS;
        end else if (iack_done_i) begin
          state_d = ST_VEC;
          if (iack_auto_i) begin
            next_vec = `EVPU_VEC_AUTO_BASE + {5'h00, iack_level_q};
          end else if (iack_uninit_i) begin
            next_vec = `EVPU_VEC_UNINIT;
          end else begin
            next_vec = iack_data_i[7:0];
          end
        end
      end
      ST_VEC: begin
        state_d = ST_HOLD;
      end
      ST_HOLD: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  evpu_vec_addr u_addr_form (
    .vec_i   (next_vec),
    .addr_o  (fa_addr),
    .space_o (fa_space),
    .words_o (fa_words)
  );

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q      <= ST_IDLE;
      iack_level_q <= 3'h0;
      vec_num_o    <= 8'h00;
      vec_addr_o   <= 32'h00000000;
      vec_space_o  <= 3'h0;
      vec_words_o  <= 3'h0;
      vec_group_o  <= 2'h0;
      vec_valid_o  <= 1'b0;
    end else begin
      state_q     <= state_d;
      vec_valid_o <= 1'b0;
      if (take_now && clr_sel == 4'h9) begin
        iack_level_q <= irq_level_i;
      end
      if (state_d == ST_VEC) begin
        vec_num_o   <= next_vec;
        vec_addr_o  <= fa_addr;
        vec_space_o <= fa_space;
        vec_words_o <= fa_words;
        vec_group_o <= (state_q == ST_IACK) ? 2'h1 : sel_grp;
        vec_valid_o <= 1'b1;
      end
    end
  end

endmodule // evpu_exception_unit

// [evpu_exception_unit_assertions.sv]
// Port checks for the exception unit.
// Assumes it is bound onto the exception unit.
`timescale 1ns/1ps
module evpu_exception_unit_assertions (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        addr_err_i,
  input wire logic        reset_req_i,
  input wire logic        take_i,
  input wire logic        exc_req_o,
  input wire logic        iack_req_o,
  input wire logic        iack_done_i,
  input wire logic        iack_auto_i,
  input wire logic        iack_berr_i,
  input wire logic        vec_valid_o,
  input wire logic        abort_o,
  input wire logic [2:0]  iack_level_o,
  input wire logic [2:0]  vec_space_o,
  input wire logic [2:0]  vec_words_o,
  input wire logic [7:0]  vec_num_o,
  input wire logic [31:0] vec_addr_o,
  input wire logic [1:0]  vec_group_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////
  a_vec_addr_form: assert property (
    vec_valid_o |-> vec_addr_o == {22'h0, vec_num_o, 2'h0}) else $error("bad vector address");
  a_reset_entry: assert property (
    vec_valid_o && vec_num_o == 8'h00 |-> vec_space_o == 3'h6 && vec_words_o == 3'h4)
    else $error("bad reset entry");
  a_other_entry: assert property (
    vec_valid_o && vec_num_o != 8'h00 |-> vec_space_o == 3'h5 && vec_words_o == 3'h2)
    else $error("bad entry space");
  a_group0_members: assert property (
    vec_valid_o && vec_group_o == 2'h0 |-> vec_num_o inside {8'h00, 8'h02, 8'h03})
    else $error("bad group 0 vector");
  a_abort_start: assert property (
    addr_err_i && !reset_req_i |-> ##[1:2] (abort_o || vec_valid_o)) else $error("late abort");
  a_take_answer: assert property (
    take_i && exc_req_o |=> vec_valid_o || iack_req_o) else $error("take not answered");
  a_auto_vector: assert property (
    iack_req_o && iack_done_i && iack_auto_i && !iack_berr_i && !reset_req_i
    |=> vec_valid_o && vec_num_o == 8'h18 + {5'h0, $past(iack_level_o)})
    else $error("bad autovector");
  a_spurious_vec: assert property (
    iack_req_o && iack_berr_i && !reset_req_i |=> vec_valid_o && vec_num_o == 8'h18)
    else $error("bad spurious");
endmodule // evpu_exception_unit_assertions

bind evpu_exception_unit evpu_exception_unit_assertions u_chk (.*);

// [evpu_periph_model.sv]
// Interrupting peripheral answering acknowledge cycles.
// Assumes the bench sets mode, vector and delay before each request.
`timescale 1ns/1ps
module evpu_periph_model (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        iack_req_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic [7:0]  vec_i,
  input  wire logic [1:0]  delay_i,
  output logic             iack_done_o,
  output logic             iack_auto_o,
  output logic             iack_berr_o,
  output logic             iack_uninit_o,
  output logic [15:0]      iack_data_o
);
  logic [1:0] cnt_q;
  ////////////////////////////////////////
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 2'h0;
      {iack_done_o, iack_auto_o, iack_berr_o, iack_uninit_o} <= 4'h0;
      iack_data_o <= 16'h0;
    end else begin
      {iack_done_o, iack_auto_o, iack_berr_o, iack_uninit_o} <= 4'h0;
      iack_data_o <= ~iack_data_o; // Released bus inverts every bit each cycle, so the old vector returns every other cycle
      if (iack_req_i && !iack_done_o && !iack_berr_o) begin
        cnt_q <= cnt_q + 2'h1;
        if (cnt_q == delay_i) begin
          cnt_q <= 2'h0;
          case (mode_i)
            2'h0: begin
              iack_done_o <= 1'b1;
              iack_data_o <= {8'ha5, vec_i}; // Vector on low byte only
            end
            2'h1: {iack_done_o, iack_auto_o} <= 2'h3;
            2'h2: iack_berr_o <= 1'b1;
            default: {iack_done_o, iack_uninit_o} <= 2'h3;
          endcase
        end
      end else if (!iack_req_i) begin
        cnt_q <= 2'h0;
      end
    end
  end
endmodule // evpu_periph_model

// [evpu_exception_unit_tb.sv]
// Self-checking bench for the exception unit.
// Assumes the peripheral model answers acknowledge cycles.
`timescale 1ns/1ps
module evpu_exception_unit_tb;
  logic clk_i = 0, rst_b_i = 0, reset_req_i = 0, bus_err_i = 0, addr_err_i = 0, take_i = 0;
  logic trace_en_i = 0, instr_done_i = 0, swi_i = 0, zero_div_i = 0;
  logic next_illegal_i = 0, next_priv_i = 0, next_line_a_i = 0, next_line_f_i = 0;
  logic overflow_trap_instr_i = 0, bounds_check_instr_i = 0;
  logic [2:0] irq_level_i = 0, irq_mask_i = 0, iack_level_o, vec_space_o, vec_words_o;
  logic [3:0] swi_num_i = 0;
  logic iack_done_i, iack_auto_i, iack_berr_i, iack_uninit_i, iack_req_o, vec_valid_o;
  logic abort_o, preempt_o, exc_req_o;
  logic [15:0] iack_data_i;
  logic [7:0] vec_num_o, pm_vec = 0;
  logic [31:0] vec_addr_o;
  logic [1:0] vec_group_o, pm_mode = 0, pm_delay = 0;
  int n_mismatch = 0, compares = 0;
  logic [7:0] src_vec [9] = '{5, 6, 7, 3, 2, 4, 8, 10, 11};
  logic [1:0] src_grp [9] = '{2, 2, 2, 0, 0, 1, 1, 1, 1};
  logic [1:0] irq_mode [6] = '{0, 0, 2, 3, 1, 1};
  logic [7:0] irq_vec [6] = '{8'h40, 8'hff, 0, 0, 0, 0};
  logic [2:0] irq_lvl [6] = '{2, 6, 4, 3, 7, 1};
  logic [7:0] irq_exp [6] = '{8'h40, 8'hff, 8'h18, 8'h0f, 8'h1f, 8'h19};
  always #25 clk_i = ~clk_i;
  evpu_exception_unit u_dut (.*);
  evpu_periph_model u_pm (.clk_i, .rst_b_i, .iack_req_i(iack_req_o), .mode_i(pm_mode),
    .vec_i(pm_vec), .delay_i(pm_delay), .iack_done_o(iack_done_i), .iack_auto_o(iack_auto_i),
    .iack_berr_o(iack_berr_i), .iack_uninit_o(iack_uninit_i), .iack_data_o(iack_data_i));
  ////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task close_out;
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task tick;
    @(negedge clk_i);
    {reset_req_i, bus_err_i, addr_err_i, swi_i, zero_div_i, instr_done_i} = 0;
    {overflow_trap_instr_i, bounds_check_instr_i} = 0;
  endtask
  task automatic wait_hi(bit sel);
    int i;
    for (i = 0; i < 20 && (sel ? vec_valid_o : exc_req_o) !== 1'b1; i++) @(negedge clk_i);
    if (i == 20) begin
      chk(sel ? "vec_valid" : "exc_req", 1, 0);
      close_out;
    end
  endtask
  task automatic expect_vec(logic [7:0] e, logic [1:0] eg);
    wait_hi(0);
    take_i = 1;
    @(negedge clk_i);
    take_i = 0;
    {next_illegal_i, next_priv_i, next_line_a_i, next_line_f_i} = 0;
    if (iack_req_o === 1'b1) chk("iack_level", irq_level_i, iack_level_o);
    wait_hi(1);
    chk("vec_num", e, vec_num_o);
    chk("vec_group", eg, vec_group_o);
    chk("vec_addr", {e, 2'h0}, vec_addr_o);
    chk("vec_space", (e == 0) ? 6 : 5, vec_space_o);
    chk("vec_words", (e == 0) ? 4 : 2, vec_words_o);
    @(negedge clk_i);
  endtask
  ////////////////////////////////////////
  task t_sources;
    for (int k = 0; k < 9; k++) begin
      {zero_div_i, bounds_check_instr_i, overflow_trap_instr_i, addr_err_i, bus_err_i,
       next_illegal_i, next_priv_i, next_line_a_i, next_line_f_i} = 9'h100 >> k;
      tick;
      expect_vec(src_vec[k], src_grp[k]);
    end
    for (int n = 0; n < 16; n += 15) begin
      swi_i = 1;
      swi_num_i = n[3:0];
      tick;
      expect_vec(8'h20 + n[7:0], 2'h2);
    end
  endtask
  task t_group0;
    addr_err_i = 1;
    bus_err_i = 1;
    tick;
    chk("abort", 1, abort_o);
    chk("preempt", 0, preempt_o);
    expect_vec(8'h03, 2'h0);
    expect_vec(8'h02, 2'h0);
    swi_i = 1;
    bus_err_i = 1;
    tick;
    expect_vec(8'h02, 2'h0);
    repeat (4) @(negedge clk_i);
    chk("exc_req", 0, exc_req_o);
    reset_req_i = 1;
    addr_err_i = 1;
    zero_div_i = 1;
    tick;
    expect_vec(8'h00, 2'h0);
    repeat (4) @(negedge clk_i);
    chk("exc_req", 0, exc_req_o);
  endtask
  task t_nest;
    irq_level_i = 3'h5;
    pm_mode = 2'h1;
    trace_en_i = 1;
    instr_done_i = 1;
    swi_i = 1;
    swi_num_i = 4'h3;
    tick;
    trace_en_i = 0;
    chk("preempt", 1, preempt_o);
    chk("abort", 0, abort_o);
    expect_vec(8'h23, 2'h2);
    expect_vec(8'h09, 2'h1);
    expect_vec(8'h1d, 2'h1);
    irq_level_i = 0;
  endtask
  task t_irq;
    for (int k = 0; k < 6; k++) begin
      pm_mode = irq_mode[k];
      pm_vec = irq_vec[k];
      pm_delay = k[1:0];
      irq_level_i = irq_lvl[k];
      irq_mask_i = (k == 4) ? 3'h7 : 3'h0;
      expect_vec(irq_exp[k], 2'h1);
      irq_level_i = 0;
      repeat (3) @(negedge clk_i);
    end
    irq_level_i = 3'h3;
    irq_mask_i = 3'h3;
    @(negedge clk_i);
    chk("exc_req", 0, exc_req_o);
    irq_mask_i = 3'h2;
    @(negedge clk_i);
    chk("exc_req", 1, exc_req_o);
    irq_level_i = 0;
    irq_mask_i = 0;
    @(negedge clk_i);
  endtask
  task t_iack_berr;
    irq_level_i = 3'h6;
    pm_mode = 2'h0;
    pm_delay = 2'h3;
    wait_hi(0);
    take_i = 1;
    @(negedge clk_i);
    take_i = 0;
    irq_level_i = 0;
    bus_err_i = 1;
    tick;
    wait_hi(1);
    chk("vec_num", 8'h18, vec_num_o);
    chk("vec_group", 1, vec_group_o);
    repeat (4) @(negedge clk_i);
    chk("exc_req", 0, exc_req_o);
  endtask
  initial begin
    repeat (8) @(negedge clk_i);
    rst_b_i = 1;
    t_sources;
    t_group0;
    t_nest;
    t_irq;
    t_iack_berr;
    close_out;
  end
endmodule // evpu_exception_unit_tb
